// file: rtl/fsm_out_pkg.sv
// constants shared by the fail-safe output manager
package fsm_out_pkg;
  localparam int          CNT_W        = 3;
  localparam logic [2:0]  CNT_START    = 3'h1;
  localparam logic [2:0]  INT_THR_ALT  = 3'h1;
  localparam logic [2:0]  FIN_THR_ALT  = 3'h2;
  localparam logic [2:0]  INT_THR_DEF  = 3'h3;
  localparam logic [2:0]  FIN_THR_DEF  = 3'h6;
  localparam logic [1:0]  WD_LIM_00    = 2'h0;
  localparam logic [1:0]  WD_LIM_01    = 2'h1;
  localparam logic [3:0]  WD_ERR_TRIP  = 4'h6;
  localparam int          CLK_HZ       = 25000000;
  localparam int          BIST_MS      = 16;
  localparam int          BIST_CYC     = BIST_MS * (CLK_HZ / 1000);
  localparam int          RST_PULSE_CYC = 16;
  localparam int          TIMER_W      = 20;
  localparam int          RPULSE_W     = 8;
  typedef enum logic [4:0] {
    ST_BIST   = 5'b00001,
    ST_RUN    = 5'b00010,
    ST_STUCK  = 5'b00100,
    ST_SAFE   = 5'b01000,
    ST_DEEP   = 5'b10000
  } mgr_state_t;
endpackage : fsm_out_pkg

// file: rtl/vote_if.sv
// interface carrying the voted counter between top and voter
`timescale 1ns/1ps
`default_nettype none
interface vote_if;
  logic [2:0] copy_a;
  logic [2:0] copy_b;
  logic [2:0] copy_c;
  logic [2:0] voted;
  logic       mismatch;
  modport voter (input copy_a, copy_b, copy_c, output voted, mismatch);
  modport user  (output copy_a, copy_b, copy_c, input voted, mismatch);
endinterface : vote_if
`default_nettype wire

// file: rtl/triple_voter.sv
// bitwise majority voter for the triplicated reset error counter
`timescale 1ns/1ps
`default_nettype none
module triple_voter (
  vote_if.voter v
);
  // majority per bit; a mismatch tells the owner to set the corrected flag
  always_comb begin
    v.voted    = (v.copy_a & v.copy_b) | (v.copy_a & v.copy_c) | (v.copy_b & v.copy_c);
    v.mismatch = (v.copy_a != v.copy_b) || (v.copy_a != v.copy_c);
  end
endmodule : triple_voter
`default_nettype wire

// file: rtl/failsafe_output_manager.sv
// fail-safe output manager: reset error counter, output mapping, pin checks, self tests
`timescale 1ns/1ps
`default_nettype none
// Contract
// - select one gives thresholds one and two
// - select zero gives thresholds three and six
// - intermediate adds failsafe; final enters deep failsafe
// - each generated reset adds exactly one
// - watchdog count six counts if limit 00/01
// - init refresh error or timeout counts
// - fault pair, supply, drift count if enabled
// - failsafe short, double error, requests count
// - three voted copies, odd copy scrubbed
// - vote correction sets corrected flag
// - counter starts at one after power-up
// - supply faults drop reset, failsafe selectable
// - external pair errors drop failsafe only
// - fault collector or drift drop both
// - watchdog error drops reset only
// - double error detect drops both
// - reference overvoltage drops both
// - reset pin mismatch flags, drops failsafe
// - failsafe pin mismatch flags, drops reset
// - logic self test after power-up
// - analog self test covers monitors, sense paths
// - tests automatic, reset held about 16 ms
// - failed test keeps reset low forever; here low-power-off exit restarts the self tests
// - logic failure stuck reset; analog failure failsafe
module failsafe_output_manager #(
  parameter int BIST_CYCLES = fsm_out_pkg::BIST_CYC
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // configuration
  input  wire logic       reset_count_threshold_sel_in,
  input  wire logic [1:0] wd_error_limit_field_in,
  input  wire logic [2:0] supply_fs_enable_in,
  input  wire logic       count_fault_pair_en_in,
  input  wire logic       count_supply_en_in,
  input  wire logic       count_drift_en_in,
  // fault events, same clock
  input  wire logic [3:0] wd_error_count_in,
  input  wire logic       wd_init_refresh_bad_in,
  input  wire logic       wd_timeout_in,
  input  wire logic       wd_error_in,
  input  wire logic [2:0] supply_ov_in,
  input  wire logic [2:0] supply_uv_in,
  input  wire logic [3:0] ref_2v5_ov_in,
  input  wire logic       ext_pair01_err_in,
  input  wire logic       ext_pair45_err_in,
  input  wire logic       mcu_fault_collector_err_in,
  input  wire logic       core_drift_in,
  input  wire logic       double_error_detect_in,
  input  wire logic       sw_reset_req_in,
  input  wire logic       low_power_off_exit_in,
  input  wire logic       wake_io0_in,
  // self test results, same clock
  input  wire logic       logic_self_test_done_in,
  input  wire logic       logic_self_test_fail_in,
  input  wire logic       analog_self_test_done_in,
  input  wire logic       analog_self_test_fail_in,
  // sensed pins
  input  wire logic       reset_pin_sense_in,
  input  wire logic       failsafe_pin_sense_in,
  // outputs
  output logic            mcu_reset_out_n_out,
  output logic            system_failsafe_out_n_out,
  output logic            regulators_off_out,
  output logic            self_test_run_out,
  output logic [2:0]      reset_error_count_out,
  output logic            counter_vote_corrected_flag_out,
  output logic            safe_state_path_fault_flag_out
);
  typedef struct packed {
    fsm_out_pkg::mgr_state_t     st;
    logic [fsm_out_pkg::TIMER_W-1:0]  tmr;
    logic [fsm_out_pkg::RPULSE_W-1:0] rpulse;
    logic [2:0] ca;
    logic [2:0] cb;
    logic [2:0] cc;
    logic       rst_n;
    logic       fs_n;
    logic       regs_off;
    logic       corr;
    logic       path_flt;
    logic [1:0] rs_sync;
    logic [1:0] fs_sync;
    logic       rs_q;
    logic       fs_q;
    logic       io0_q;
    logic       io0_prev;
    logic       wd_trip_prev;
    logic [2:0] rst_d;
    logic [2:0] fs_d;
    logic       io0_meta;
    logic       ext_prev;
    logic       fss_prev;
    logic       st_run;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  vote_if vif ();

  triple_voter u_voter (.v(vif.voter));

  assign vif.copy_a = s_r.ca;
  assign vif.copy_b = s_r.cb;
  assign vif.copy_c = s_r.cc;

  // saturating increment, used only by the event path; the scrub path copies the voted value
  function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic [2:0] lim);
    sat_inc = (v >= lim) ? lim : 3'(v + 3'h1);
  endfunction : sat_inc

  logic [2:0] thr_int;
  logic [2:0] thr_fin;
  logic       wd_trip;
  logic       cnt_evt;
  logic       gen_reset;
  logic       fs_fault;
  logic       rst_fault;
  logic       rst_mis;
  logic       fs_mis;
  logic [2:0] cnt_new;
  logic       ext_rst;
  logic       fs_short;

  // threshold pair chosen by the select bit
  always_comb begin
    thr_int = reset_count_threshold_sel_in ? fsm_out_pkg::INT_THR_ALT
                                           : fsm_out_pkg::INT_THR_DEF;
    thr_fin = reset_count_threshold_sel_in ? fsm_out_pkg::FIN_THR_ALT
                                           : fsm_out_pkg::FIN_THR_DEF;
  end

  // fault to output mapping and pin checks
  always_comb begin
    wd_trip = (wd_error_count_in == fsm_out_pkg::WD_ERR_TRIP) &&
              ((wd_error_limit_field_in == fsm_out_pkg::WD_LIM_00) ||
               (wd_error_limit_field_in == fsm_out_pkg::WD_LIM_01));
    // compare each sensed pin with its command delayed by the sense latency;
    // a plain compare would flag every legal edge of a pin for three cycles
    rst_mis  = (s_r.rst_d[2] != s_r.rs_q);
    fs_mis   = (s_r.fs_d[2] != s_r.fs_q);
    ext_rst  = !s_r.rs_q && s_r.rst_d[2];
    fs_short = s_r.fs_q && !s_r.fs_d[2];
    rst_fault = (|supply_ov_in) || (|supply_uv_in)
              || mcu_fault_collector_err_in || core_drift_in
              || wd_error_in
              || wd_init_refresh_bad_in || wd_timeout_in
              || sw_reset_req_in
              || double_error_detect_in
              || (|ref_2v5_ov_in)
              || fs_mis;
    fs_fault  = (|((supply_ov_in | supply_uv_in) & supply_fs_enable_in))
              || ext_pair01_err_in || ext_pair45_err_in
              || mcu_fault_collector_err_in || core_drift_in
              || double_error_detect_in
              || (|ref_2v5_ov_in)
              || rst_mis;
    // a new reset pulse starts only when none is running, so one pulse counts once
    gen_reset = rst_fault && (s_r.rpulse == '0) && s_r.rst_n;
    cnt_evt = gen_reset
            || (wd_trip && !s_r.wd_trip_prev)
            || wd_init_refresh_bad_in || wd_timeout_in
            || (count_fault_pair_en_in && mcu_fault_collector_err_in)
            || (count_supply_en_in && ((|supply_ov_in) || (|supply_uv_in)))
            || (count_drift_en_in && core_drift_in)
            // double error counts through the reset it generates, once per pulse
            || (fs_short && !s_r.fss_prev)
            || sw_reset_req_in
            || (ext_rst && !s_r.ext_prev);
    cnt_new = cnt_evt ? sat_inc(vif.voted, thr_fin) : vif.voted;
  end

  // next-state logic of the whole manager
  always_comb begin
    s_nxt = s_r;
    s_nxt.rs_sync = {s_r.rs_sync[0], reset_pin_sense_in};
    s_nxt.fs_sync = {s_r.fs_sync[0], failsafe_pin_sense_in};
    s_nxt.rs_q = s_r.rs_sync[1];
    s_nxt.fs_q = s_r.fs_sync[1];
    s_nxt.io0_prev = s_r.io0_q;
    s_nxt.io0_q = s_r.io0_meta;
    s_nxt.io0_meta = wake_io0_in;
    s_nxt.wd_trip_prev = wd_trip;
    // command history matching the pin sense latency
    s_nxt.rst_d = {s_r.rst_d[1:0], s_r.rst_n};
    s_nxt.fs_d = {s_r.fs_d[1:0], s_r.fs_n};
    s_nxt.ext_prev = ext_rst;
    s_nxt.fss_prev = fs_short;
    // scrub: every copy rewritten with the voted value each cycle
    s_nxt.ca = vif.voted;
    s_nxt.cb = vif.voted;
    s_nxt.cc = vif.voted;
    if (vif.mismatch) begin
      s_nxt.corr = 1'b1;
    end
    if (rst_mis || fs_mis) begin
      s_nxt.path_flt = 1'b1;
    end
    unique case (s_r.st)
      fsm_out_pkg::ST_BIST: begin
        // both self tests run on their own; reset is held meanwhile
        s_nxt.rst_n = 1'b0;
        s_nxt.fs_n  = 1'b0;
        // timer holds at its end so a late done never sees a wrapped count
        if (32'(s_r.tmr) < BIST_CYCLES - 1) begin
          s_nxt.tmr = s_r.tmr + 1'b1;
        end
        if (logic_self_test_done_in && logic_self_test_fail_in) begin
          s_nxt.st = fsm_out_pkg::ST_STUCK;
        end else if (analog_self_test_done_in && analog_self_test_fail_in) begin
          s_nxt.st = fsm_out_pkg::ST_SAFE;
        end else if ((32'(s_r.tmr) >= BIST_CYCLES - 1) && logic_self_test_done_in &&
                     analog_self_test_done_in) begin
          s_nxt.st    = fsm_out_pkg::ST_RUN;
          s_nxt.rst_n = 1'b1;
          s_nxt.tmr   = '0;
        end
      end
      fsm_out_pkg::ST_RUN: begin
        s_nxt.ca = cnt_new;
        s_nxt.cb = cnt_new;
        s_nxt.cc = cnt_new;
        if (gen_reset) begin
          s_nxt.rpulse = fsm_out_pkg::RPULSE_W'(fsm_out_pkg::RST_PULSE_CYC);
        end else if (s_r.rpulse != '0) begin
          s_nxt.rpulse = s_r.rpulse - 1'b1;
        end
        // reset stays low while the pulse runs or the fault persists
        s_nxt.rst_n = !(gen_reset || (s_r.rpulse > 1) || rst_fault);
        // failsafe follows its own faults, escalating at the intermediate level
        s_nxt.fs_n  = !(fs_fault || (cnt_new >= thr_int));
        if (cnt_new >= thr_fin) begin
          s_nxt.st       = fsm_out_pkg::ST_DEEP;
          s_nxt.regs_off = 1'b1;
          s_nxt.rst_n    = 1'b0;
          s_nxt.fs_n     = 1'b0;
        end
      end
      fsm_out_pkg::ST_STUCK: begin
        s_nxt.rst_n = 1'b0;
        s_nxt.fs_n  = 1'b0;
      end
      fsm_out_pkg::ST_SAFE: begin
        s_nxt.rst_n = 1'b0;
        s_nxt.fs_n  = 1'b0;
      end
      fsm_out_pkg::ST_DEEP: begin
        s_nxt.rst_n    = 1'b0;
        s_nxt.fs_n     = 1'b0;
        s_nxt.regs_off = 1'b1;
        if (s_r.io0_q != s_r.io0_prev) begin
          s_nxt.st       = fsm_out_pkg::ST_BIST;
          s_nxt.regs_off = 1'b0;
          s_nxt.tmr      = '0;
          s_nxt.ca       = fsm_out_pkg::CNT_START;
          s_nxt.cb       = fsm_out_pkg::CNT_START;
          s_nxt.cc       = fsm_out_pkg::CNT_START;
        end
      end
      default: begin
        s_nxt.st = fsm_out_pkg::ST_SAFE;
      end
    endcase
    // leaving low-power-off restarts self tests with the counter at one
    if (low_power_off_exit_in) begin
      s_nxt.st       = fsm_out_pkg::ST_BIST;
      s_nxt.tmr      = '0;
      s_nxt.rpulse   = '0;
      s_nxt.regs_off = 1'b0;
      s_nxt.rst_n    = 1'b0;
      s_nxt.fs_n     = 1'b0;
      s_nxt.ca       = fsm_out_pkg::CNT_START;
      s_nxt.cb       = fsm_out_pkg::CNT_START;
      s_nxt.cc       = fsm_out_pkg::CNT_START;
    end
    s_nxt.st_run = (s_nxt.st == fsm_out_pkg::ST_BIST);
  end

  // single state register; power-on reset puts the counter at one
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '{st: fsm_out_pkg::ST_BIST, tmr: '0, rpulse: '0,
               ca: fsm_out_pkg::CNT_START, cb: fsm_out_pkg::CNT_START,
               cc: fsm_out_pkg::CNT_START, rst_n: 1'b0, fs_n: 1'b0,
               regs_off: 1'b0, corr: 1'b0, path_flt: 1'b0, rs_sync: 2'h0,
               fs_sync: 2'h0, rs_q: 1'b0, fs_q: 1'b0, io0_q: 1'b0,
               io0_prev: 1'b0, wd_trip_prev: 1'b0, rst_d: 3'h0, fs_d: 3'h0,
               io0_meta: 1'b0, ext_prev: 1'b0, fss_prev: 1'b0,
               st_run: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign mcu_reset_out_n_out             = s_r.rst_n;
  assign system_failsafe_out_n_out       = s_r.fs_n;
  assign regulators_off_out              = s_r.regs_off;
  assign self_test_run_out               = s_r.st_run;
  assign reset_error_count_out           = s_r.ca;
  assign counter_vote_corrected_flag_out = s_r.corr;
  assign safe_state_path_fault_flag_out  = s_r.path_flt;

  // checks
  copies_agree_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.ca == s_r.cb) && (s_r.cb == s_r.cc))
    else $error("counter copies disagree");
  corr_flag_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    vif.mismatch |=> s_r.corr)
    else $error("vote correction not flagged");
  sat_limit_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_r.ca <= fsm_out_pkg::FIN_THR_DEF)
    else $error("counter beyond final threshold");
  deep_entry_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.st == fsm_out_pkg::ST_RUN && cnt_new >= thr_fin && !low_power_off_exit_in)
    |=> (s_r.st == fsm_out_pkg::ST_DEEP) && s_r.regs_off)
    else $error("final threshold did not enter deep failsafe");
  bist_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.st == fsm_out_pkg::ST_BIST) |-> !s_r.rst_n)
    else $error("reset released during self test");
  stuck_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.st == fsm_out_pkg::ST_STUCK) && !low_power_off_exit_in
    |=> $stable(s_r.st) && !s_r.rst_n)
    else $error("left stuck state");
  ext_pair_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.st == fsm_out_pkg::ST_RUN && ext_pair01_err_in && !low_power_off_exit_in)
    |=> !s_r.fs_n)
    else $error("external pair error kept failsafe high");
  dde_both_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.st == fsm_out_pkg::ST_RUN && double_error_detect_in && !low_power_off_exit_in)
    |=> !s_r.fs_n && !s_r.rst_n)
    else $error("double error did not drop both");
  rst_mis_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rst_mis |=> s_r.path_flt)
    else $error("reset mismatch not flagged");
  inc_one_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.st == fsm_out_pkg::ST_RUN && !low_power_off_exit_in && !vif.mismatch)
    |=> (s_r.ca == $past(s_r.ca)) || (s_r.ca == 3'($past(s_r.ca) + 3'h1)))
    else $error("counter moved by more than one");
  cov_deep_c: cover property (@(posedge clk_in) s_r.st == fsm_out_pkg::ST_DEEP);
  cov_run_c: cover property (@(posedge clk_in) s_r.st == fsm_out_pkg::ST_RUN);
  cov_corr_c: cover property (@(posedge clk_in) vif.mismatch);
  fs_mis_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    fs_mis |=> s_r.path_flt)
    else $error("failsafe mismatch not flagged");
  wd_reset_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.st == fsm_out_pkg::ST_RUN && wd_error_in && !low_power_off_exit_in)
    |=> !s_r.rst_n)
    else $error("watchdog error kept reset high");
  pulse_len_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (s_r.st == fsm_out_pkg::ST_RUN && gen_reset && !low_power_off_exit_in)
    |=> !s_r.rst_n [*8])
    else $error("generated reset pulse too short");
  cov_ext_c: cover property (@(posedge clk_in) ext_rst && !s_r.ext_prev);
  cov_stuck_c: cover property (@(posedge clk_in) s_r.st == fsm_out_pkg::ST_STUCK);
endmodule : failsafe_output_manager
`default_nettype wire

// file: tb/host_partner.sv
// partner model: mcu reset pin and safety switch line as seen by the sense paths
`timescale 1ns/1ps
`default_nettype none
module host_partner (
  // commands from the device
  input  wire logic mcu_reset_n_in,
  input  wire logic failsafe_n_in,
  // pin faults imposed by the bench
  input  wire logic rst_short_high_in,
  input  wire logic fs_short_high_in,
  input  wire logic mcu_hold_low_in,
  // sensed pin levels
  output logic      reset_sense_out,
  output logic      failsafe_sense_out
);
  // open-drain pins with pull-ups: a short to high wins over any driver
  assign reset_sense_out    = rst_short_high_in | (mcu_reset_n_in & ~mcu_hold_low_in);
  assign failsafe_sense_out = fs_short_high_in | failsafe_n_in;
endmodule : host_partner
`default_nettype wire

// file: tb/tb_failsafe_output_manager.sv
// self-checking bench of the fail-safe output manager
`timescale 1ns/1ps
`default_nettype none
module tb_failsafe_output_manager;
  localparam int BIST_N = 20;
  // fault table: {reset_n, failsafe_n} expected per fault index
  localparam logic [1:0] EXP_TAB [0:11] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1,
                                             2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
  logic       clk_in, rst_b_in, thr_sel, en_pair, en_sup, en_drift;
  logic [1:0] wd_lim;
  logic [2:0] sup_fs_en, sup_ov, sup_uv, cnt;
  logic [3:0] wd_cnt, ref_ov;
  logic       wd_init_bad, wd_to, wd_err, pair01, pair45, fcc_err, drift, ded, sw_req;
  logic       low_power_off_state_exit, wake0, lst_done, lst_fail, ast_done, ast_fail;
  logic       rst_short, fs_short, mcu_hold, rst_sense, fs_sense;
  logic       mcu_rst_n, fs_out_n, regs_off, st_run, vote_flag, path_flag;
  int         n_mismatch = 0;
  int         num_checks = 0;

  failsafe_output_manager #(.BIST_CYCLES(BIST_N)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in),
    .reset_count_threshold_sel_in(thr_sel), .wd_error_limit_field_in(wd_lim),
    .supply_fs_enable_in(sup_fs_en), .count_fault_pair_en_in(en_pair),
    .count_supply_en_in(en_sup), .count_drift_en_in(en_drift),
    .wd_error_count_in(wd_cnt), .wd_init_refresh_bad_in(wd_init_bad),
    .wd_timeout_in(wd_to), .wd_error_in(wd_err), .supply_ov_in(sup_ov),
    .supply_uv_in(sup_uv), .ref_2v5_ov_in(ref_ov), .ext_pair01_err_in(pair01),
    .ext_pair45_err_in(pair45), .mcu_fault_collector_err_in(fcc_err),
    .core_drift_in(drift), .double_error_detect_in(ded), .sw_reset_req_in(sw_req),
    .low_power_off_exit_in(low_power_off_state_exit), .wake_io0_in(wake0),
    .logic_self_test_done_in(lst_done), .logic_self_test_fail_in(lst_fail),
    .analog_self_test_done_in(ast_done), .analog_self_test_fail_in(ast_fail),
    .reset_pin_sense_in(rst_sense), .failsafe_pin_sense_in(fs_sense),
    .mcu_reset_out_n_out(mcu_rst_n), .system_failsafe_out_n_out(fs_out_n),
    .regulators_off_out(regs_off), .self_test_run_out(st_run),
    .reset_error_count_out(cnt), .counter_vote_corrected_flag_out(vote_flag),
    .safe_state_path_fault_flag_out(path_flag));

  host_partner partner (
    .mcu_reset_n_in(mcu_rst_n), .failsafe_n_in(fs_out_n),
    .rst_short_high_in(rst_short), .fs_short_high_in(fs_short),
    .mcu_hold_low_in(mcu_hold), .reset_sense_out(rst_sense),
    .failsafe_sense_out(fs_sense));

  // 25 mhz clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // inputs always change 1 ns after the edge so sampling never races
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // full power-on: all faults quiet, tests pass, analog supply kept off failsafe
  task automatic power_up(input logic s);
    rst_b_in = 1'b0;
    {en_pair, en_sup, en_drift, wd_lim, sup_ov, sup_uv, wd_cnt, ref_ov} = '0;
    {wd_init_bad, wd_to, wd_err, pair01, pair45, fcc_err, drift, ded, sw_req} = '0;
    {low_power_off_state_exit, wake0, lst_fail, ast_fail, rst_short, fs_short, mcu_hold} = '0;
    {lst_done, ast_done, thr_sel, sup_fs_en} = {2'h3, s, 3'h5};
    cyc(20);
    chk(cnt, 8'h1, "count in reset");
    rst_b_in = 1'b1;
    cyc(BIST_N - 5);
    chk({st_run, mcu_rst_n}, 8'h2, "self test hold");
    cyc(20);
    chk({st_run, mcu_rst_n, cnt}, 8'h09, "released");
  endtask : power_up

  // one-cycle counting event followed by the generated reset pulse
  task automatic fire(input int k);
    case (k)
      0: sw_req = 1'b1;
      1: wd_init_bad = 1'b1;
      default: wd_to = 1'b1;
    endcase
    cyc(1);
    {sw_req, wd_init_bad, wd_to} = 3'h0;
    cyc(4);
    chk(mcu_rst_n, 8'h0, "reset pulse");
    cyc(26);
  endtask : fire

  task automatic set_fault(input int k, input logic v);
    case (k)
      0: pair01 = v;
      1: pair45 = v;
      2: fcc_err = v;
      3: drift = v;
      4: ded = v;
      5: wd_err = v;
      10: sup_ov[0] = v;
      11: sup_uv[1] = v;
      default: ref_ov[k-6] = v;
    endcase
  endtask : set_fault

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // watchdog sized well above the whole sequence
  initial begin
    #(40 * 20000);
    n_mismatch++;
    stop_test();
  end

  initial begin
    int ev [3] = '{2, 10, 3};
    // default thresholds: escalate, enter deep failsafe, saturate, wake
    power_up(1'b0);
    for (int i = 2; i <= 7; i++) begin
      fire(0);
      chk(cnt, (i > 6) ? 8'h6 : 8'(i), "count step");
      chk({fs_out_n, regs_off}, {6'h0, i < 3, i >= 6}, "escalation");
    end
    chk({vote_flag, path_flag}, 8'h0, "clean flags");
    wake0 = 1'b1;
    cyc(BIST_N + 30);
    chk({regs_off, mcu_rst_n, cnt}, 8'h09, "wake exit");
    // alternate thresholds one and two
    power_up(1'b1);
    chk(fs_out_n, 8'h0, "alt intermediate");
    fire(0);
    chk({regs_off, cnt}, 8'h0a, "alt final");
    // watchdog counting sources and limit field
    power_up(1'b0);
    for (int l = 0; l < 4; l++) begin
      wd_lim = 2'(l);
      wd_cnt = 4'h6;
      cyc(1);
      wd_cnt = 4'h0;
      cyc(30);
      chk(cnt, (l == 0) ? 8'h2 : 8'h3, "wd limit");
    end
    power_up(1'b0);
    fire(1);
    fire(2);
    chk(cnt, 8'h3, "wd init and timeout");
    // configurable counting sources
    power_up(1'b0);
    {en_pair, en_sup, en_drift} = 3'h7;
    for (int i = 0; i < 3; i++) begin
      set_fault(ev[i], 1'b1);
      cyc(1);
      set_fault(ev[i], 1'b0);
      cyc(30);
      chk(cnt, 8'(i + 2), "enabled source");
    end
    // fault to output mapping
    for (int k = 0; k < 12; k++) begin
      power_up(1'b0);
      set_fault(k, 1'b1);
      cyc(3);
      chk({mcu_rst_n, fs_out_n}, 8'(EXP_TAB[k]), "fault map");
    end
    // pin sense mismatches in both directions
    power_up(1'b0);
    wd_err = 1'b1;
    cyc(3);
    rst_short = 1'b1;
    cyc(6);
    chk({path_flag, fs_out_n}, 8'h2, "reset pin stuck");
    power_up(1'b0);
    pair01 = 1'b1;
    cyc(3);
    fs_short = 1'b1;
    cyc(6);
    chk({path_flag, mcu_rst_n}, 8'h2, "failsafe pin stuck");
    // externally held reset counts once
    power_up(1'b0);
    mcu_hold = 1'b1;
    cyc(2);
    mcu_hold = 1'b0;
    cyc(30);
    chk(cnt, 8'h2, "external reset");
    // a held double error counts once, through its reset pulse
    ded = 1'b1;
    cyc(5);
    ded = 1'b0;
    cyc(30);
    chk(cnt, 8'h3, "double error once");
    // leaving low-power-off restarts tests and the counter
    power_up(1'b0);
    fire(0);
    low_power_off_state_exit = 1'b1;
    cyc(1);
    low_power_off_state_exit = 1'b0;
    cyc(3);
    chk({st_run, mcu_rst_n}, 8'h2, "low_power_off_state restart");
    cyc(BIST_N + 30);
    chk({mcu_rst_n, cnt}, 8'h9, "low_power_off_state count");
    // failing self tests never release reset
    for (int f = 0; f < 2; f++) begin
      power_up(1'b0);
      rst_b_in = 1'b0;
      {lst_fail, ast_fail} = (f == 0) ? 2'h2 : 2'h1;
      cyc(2);
      rst_b_in = 1'b1;
      cyc(200);
      chk({mcu_rst_n, fs_out_n}, 8'h0, "self test fail");
    end
    stop_test();
  end
endmodule : tb_failsafe_output_manager
`default_nettype wire
